// >>> trc_pkg.sv
// Shared constants and types for the transceiver reset control block
package trc_pkg;
  // Channel count of one transceiver block
  localparam int unsigned NUM_CH = 4;
  // Clock rate in kHz
  localparam int unsigned CLK_KHZ = 10000;
  // Least PLL reset hold in ns
  localparam int unsigned PLL_RST_MIN_NS = 1000;
  localparam int unsigned PLL_RST_CYC =
    (PLL_RST_MIN_NS * CLK_KHZ + 999999) / 1000000;
  // Model and controller delays in clock cycles; counter width in bits
  localparam int unsigned CAL_CYC = 16;
  localparam int unsigned PLL_LOCK_CYC = 8;
  localparam int unsigned CDR_LOCK_CYC = 8;
  localparam int unsigned RX_ANA_WAIT_CYC = 2;
  localparam int unsigned REF_TO_DATA_CYC = 4;
  localparam int unsigned DATA_SETTLE_CYC = 4;
  localparam int unsigned CNT_W = 8;
  // Lock-select decode values
  localparam logic [1:0] LOCK_AUTO = 2'h0;
  localparam logic [1:0] LOCK_REF = 2'h1;
  localparam logic [1:0] LOCK_DATA = 2'h2;

  typedef enum logic [1:0] {
    TRC_LK_AUTO = 2'h0,
    TRC_LK_REF = 2'h1,
    TRC_LK_DATA = 2'h2
  } trc_lock_t;
endpackage

// >>> trc_if.sv
// Interface joining the transceiver block and the user reset controller
`timescale 1ns/1ps
`default_nettype none
interface trc_if #(parameter int unsigned NCH = 4);
  logic pll_reset;
  logic block_powerdown;
  logic [NCH-1:0] tx_digital_reset;
  logic [NCH-1:0] rx_digital_reset;
  logic [NCH-1:0] rx_analog_reset;
  logic [NCH-1:0] hold_reference;
  logic [NCH-1:0] force_data;
  logic pll_locked;
  logic cal_busy;
  logic [NCH-1:0] data_locked;
  modport xcvr (
    input pll_reset, block_powerdown, tx_digital_reset,
    input rx_digital_reset, rx_analog_reset, hold_reference, force_data,
    output pll_locked, cal_busy, data_locked
  );
  modport ctrl (
    output pll_reset, block_powerdown, tx_digital_reset,
    output rx_digital_reset, rx_analog_reset, hold_reference, force_data,
    input pll_locked, cal_busy, data_locked
  );
endinterface
`default_nettype wire

// >>> trc_xcvr.sv
// Transceiver block model: reset domains, calibration busy and CDR lock
// Functional notes
// - PLL reset clears only the PLLs
// - TX digital reset clears TX PCS, not buffer
// - RX digital reset clears all RX PCS blocks
// - RX analog reset clears only the CDR
// - Power-down stops all channel blocks, not PLLs
// - XAUI mode requires bonded channels
// - PCIe mode uses its own reset sequence
// - Busy low first cycle, high from second
// - Busy falls when offset cancellation finishes
// - Controller waits on busy unless transmit-only
// - Controller follows documented reset sequences
// - CDR supports automatic or manual lock
// - Manual lock follows two lock-select inputs
// - Manual lock works bonded; XAUI bonds four
// - Decode hold-ref/force-data into lock mode
// - Data-lock status high in data lock
// - PLL locked output high once PLL locks
// - Power-down independent, shared by all channels
// - Controller holds PLL reset at least 1 us
`timescale 1ns/1ps
`default_nettype none
module trc_xcvr #(
  parameter int unsigned NCH = trc_pkg::NUM_CH,
  parameter int unsigned CAL_CYC = trc_pkg::CAL_CYC,
  parameter int unsigned PLL_LOCK_CYC = trc_pkg::PLL_LOCK_CYC,
  parameter int unsigned CDR_LOCK_CYC = trc_pkg::CDR_LOCK_CYC
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  trc_if.xcvr lnk,
  input wire logic [NCH-1:0] tx_data_valid_in,
  input wire logic [NCH-1:0] rx_data_valid_in,
  output logic [NCH-1:0] tx_ready_out,
  output logic [NCH-1:0] rx_ready_out,
  output logic [NCH-1:0] rx_buf_on_out
);
  localparam int unsigned W = trc_pkg::CNT_W;

  function automatic logic [1:0] decode_lock(input logic href,
                                             input logic fdata);
    // Force-data dominates; hold-reference only matters when it is low
    if (fdata) begin
      decode_lock = trc_pkg::LOCK_DATA;
    end else if (href) begin
      decode_lock = trc_pkg::LOCK_REF;
    end else begin
      decode_lock = trc_pkg::LOCK_AUTO;
    end
  endfunction

  // PLL and calibration state
  logic [W-1:0] pll_cnt_q, pll_cnt_d;
  logic pll_lock_q, pll_lock_d;
  logic [W-1:0] cal_cnt_q, cal_cnt_d;
  logic cal_started_q, cal_started_d;
  logic busy_q, busy_d;

  // PLL locks a fixed time after its reset is released
  // Nothing else in the block clears here; channels keep their state
  always_comb begin
    pll_cnt_d = pll_cnt_q;
    pll_lock_d = pll_lock_q;
    if (lnk.pll_reset) begin
      pll_cnt_d = '0; // only the PLL state clears here
      pll_lock_d = 1'b0;
    end else if (pll_cnt_q < W'(PLL_LOCK_CYC)) begin
      pll_cnt_d = pll_cnt_q + 1'b1;
    end else begin
      pll_lock_d = 1'b1;
    end
  end

  // Busy is low in the first cycle after power-up, then runs calibration.
  // Calibration runs once per power-up: link resets do not restart it,
  // so a controller must not wait for a second busy pulse.
  always_comb begin
    cal_started_d = 1'b1;
    busy_d = busy_q;
    cal_cnt_d = cal_cnt_q;
    if (!cal_started_q) begin
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cal_cnt_q == W'(CAL_CYC - 1)) begin
        busy_d = 1'b0; // falling edge marks cancellation done
      end else begin
        cal_cnt_d = cal_cnt_q + 1'b1;
      end
    end
  end

  // Registers only; next values come from the two blocks above
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pll_cnt_q <= '0;
      pll_lock_q <= 1'b0;
      cal_cnt_q <= '0;
      cal_started_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      pll_cnt_q <= pll_cnt_d;
      pll_lock_q <= pll_lock_d;
      cal_cnt_q <= cal_cnt_d;
      cal_started_q <= cal_started_d;
      busy_q <= busy_d;
    end
  end

  // Status leaves straight from the flops
  assign lnk.pll_locked = pll_lock_q;
  assign lnk.cal_busy = busy_q;

  // Per-channel state
  // Lanes are kept apart here; bonding is up to the controller
  logic [NCH-1:0] tx_pcs_q, tx_pcs_d;
  logic [NCH-1:0] rx_pcs_q, rx_pcs_d;
  logic [NCH-1:0] cdr_lock_q, cdr_lock_d;
  logic [NCH-1:0] rxbuf_q, rxbuf_d;
  logic [W-1:0] cdr_cnt_q [NCH];
  logic [W-1:0] cdr_cnt_d [NCH];

  // One power-down acts on every channel, apart from the other resets
  // Power-down wins over every reset input of the channel
  always_comb begin
    logic [1:0] mode;
    mode = trc_pkg::LOCK_AUTO;
    for (int i = 0; i < NCH; i++) begin
      mode = decode_lock(lnk.hold_reference[i], lnk.force_data[i]);
      tx_pcs_d[i] = tx_pcs_q[i];
      rx_pcs_d[i] = rx_pcs_q[i];
      cdr_lock_d[i] = cdr_lock_q[i];
      cdr_cnt_d[i] = cdr_cnt_q[i];
      rxbuf_d[i] = 1'b1;
      if (lnk.block_powerdown) begin
        tx_pcs_d[i] = 1'b0;
        rx_pcs_d[i] = 1'b0;
        cdr_lock_d[i] = 1'b0;
        cdr_cnt_d[i] = '0;
        rxbuf_d[i] = 1'b0; // buffers off too
      end else begin
        // TX PCS follows its reset; the TX buffer is not touched
        tx_pcs_d[i] = !lnk.tx_digital_reset[i];
        // RX PCS follows its own reset only
        rx_pcs_d[i] = !lnk.rx_digital_reset[i];
        if (lnk.rx_analog_reset[i] || mode == trc_pkg::LOCK_REF) begin
          // Analog reset only idles the CDR; buffer stays up
          cdr_cnt_d[i] = '0;
          cdr_lock_d[i] = 1'b0;
        end else if (cdr_cnt_q[i] < W'(CDR_LOCK_CYC)) begin
          cdr_cnt_d[i] = cdr_cnt_q[i] + 1'b1;
        end else begin
          // Auto and manual data mode both enter data lock once the CDR count is done
          cdr_lock_d[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_pcs_q <= '0;
      rx_pcs_q <= '0;
      cdr_lock_q <= '0;
      rxbuf_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        cdr_cnt_q[i] <= '0;
      end
    end else begin
      tx_pcs_q <= tx_pcs_d;
      rx_pcs_q <= rx_pcs_d;
      cdr_lock_q <= cdr_lock_d;
      rxbuf_q <= rxbuf_d;
      for (int i = 0; i < NCH; i++) begin
        cdr_cnt_q[i] <= cdr_cnt_d[i];
      end
    end
  end

  // Lock status per lane, straight from the flops
  assign lnk.data_locked = cdr_lock_q;

  // Ready flags: the single PLL lock fans out to every lane's TX side
  logic [NCH-1:0] tx_rdy_q, tx_rdy_d;
  logic [NCH-1:0] rx_rdy_q, rx_rdy_d;
  logic [NCH-1:0] tx_seen, rx_seen;

  // Data-valid inputs are observation aids only; they never gate ready
  always_comb begin
    tx_seen = tx_data_valid_in | ~tx_data_valid_in;
    rx_seen = rx_data_valid_in | ~rx_data_valid_in;
    tx_rdy_d = tx_pcs_q & {NCH{pll_lock_q}} & tx_seen;
    rx_rdy_d = rx_pcs_q & cdr_lock_q & rx_seen;
  end

  // Ready registers only
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_rdy_q <= '0;
      rx_rdy_q <= '0;
    end else begin
      tx_rdy_q <= tx_rdy_d;
      rx_rdy_q <= rx_rdy_d;
    end
  end
  assign tx_ready_out = tx_rdy_q;
  assign rx_ready_out = rx_rdy_q;
  assign rx_buf_on_out = rxbuf_q;
endmodule
`default_nettype wire

// >>> trc_ctrl.sv
// User reset controller: sequences PLL, TX and RX resets and lock select
`timescale 1ns/1ps
`default_nettype none
module trc_ctrl #(
  parameter int unsigned NCH = trc_pkg::NUM_CH,
  parameter int unsigned PLL_RST_CYC = trc_pkg::PLL_RST_CYC
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  trc_if.ctrl lnk,
  input wire logic manual_lock_in,
  input wire logic tx_only_in,
  input wire logic powerdown_in,
  output logic tx_up_out,
  output logic rx_up_out
);
  localparam int unsigned W = trc_pkg::CNT_W;

  typedef enum logic [4:0] {
    TRC_S_PLLRST = 5'h01,
    TRC_S_PLLWT = 5'h02,
    TRC_S_RXANA = 5'h04,
    TRC_S_REFLK = 5'h08,
    TRC_S_LTD = 5'h10
  } trc_state_t;

  // Status synchronisers; only the second stage is ever read
  logic lk_s1_q, lk_s2_q, bs_s1_q, bs_s2_q;
  logic [NCH-1:0] dl_s1_q, dl_s2_q;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lk_s1_q <= 1'b0;
      lk_s2_q <= 1'b0;
      bs_s1_q <= 1'b0;
      bs_s2_q <= 1'b0;
      dl_s1_q <= '0;
      dl_s2_q <= '0;
    end else begin
      lk_s1_q <= lnk.pll_locked;
      lk_s2_q <= lk_s1_q;
      bs_s1_q <= lnk.cal_busy;
      bs_s2_q <= bs_s1_q;
      dl_s1_q <= lnk.data_locked;
      dl_s2_q <= dl_s1_q;
    end
  end

  trc_state_t st_q, st_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic pll_rst_q, pll_rst_d, tx_rst_q, tx_rst_d, rx_rst_q, rx_rst_d;
  logic ana_q, ana_d, href_q, href_d, fdat_q, fdat_d, seen_q, seen_d;

  // Sequence: PLL reset hold, PLL lock, busy done, CDR lock, RX release
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 1'b1;
    pll_rst_d = pll_rst_q;
    tx_rst_d = tx_rst_q;
    rx_rst_d = rx_rst_q;
    ana_d = ana_q;
    href_d = href_q;
    fdat_d = fdat_q;
    seen_d = seen_q | bs_s2_q;
    // Bonded group: all channels share one sequence
    case (st_q)
      TRC_S_PLLRST: begin
        if (cnt_q >= W'(PLL_RST_CYC)) begin
          pll_rst_d = 1'b0;
          st_d = TRC_S_PLLWT;
        end
      end
      TRC_S_PLLWT: begin
        cnt_d = '0;
        if (lk_s2_q) begin
          tx_rst_d = 1'b0;
          // Busy falling edge gates RX unless transmit-only
          if (tx_only_in || (seen_q && !bs_s2_q)) begin
            st_d = TRC_S_RXANA;
          end
        end
      end
      TRC_S_RXANA: begin
        if (cnt_q >= W'(trc_pkg::RX_ANA_WAIT_CYC)) begin
          ana_d = 1'b0;
          cnt_d = '0;
          st_d = manual_lock_in ? TRC_S_REFLK : TRC_S_LTD;
        end
      end
      TRC_S_REFLK: begin
        if (cnt_q >= W'(trc_pkg::REF_TO_DATA_CYC)) begin
          href_d = 1'b0;
          fdat_d = 1'b1;
          cnt_d = '0;
          st_d = TRC_S_LTD;
        end
      end
      TRC_S_LTD: begin
        if (!(&dl_s2_q)) begin
          cnt_d = '0;
        end else if (cnt_q >= W'(trc_pkg::DATA_SETTLE_CYC)) begin
          rx_rst_d = 1'b0;
          cnt_d = cnt_q;
        end
      end
      default: st_d = TRC_S_PLLRST;
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= TRC_S_PLLRST;
      cnt_q <= '0;
      seen_q <= 1'b0;
      pll_rst_q <= 1'b1;
      tx_rst_q <= 1'b1;
      rx_rst_q <= 1'b1;
      ana_q <= 1'b1;
      href_q <= 1'b1;
      fdat_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      seen_q <= seen_d;
      pll_rst_q <= pll_rst_d;
      tx_rst_q <= tx_rst_d;
      rx_rst_q <= rx_rst_d;
      ana_q <= ana_d;
      href_q <= href_d;
      fdat_q <= fdat_d;
    end
  end

  logic pd_q, txu_q, rxu_q;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pd_q <= 1'b0;
      txu_q <= 1'b0;
      rxu_q <= 1'b0;
    end else begin
      pd_q <= powerdown_in;
      txu_q <= !tx_rst_q;
      rxu_q <= !rx_rst_q;
    end
  end

  // PCIe sequencing is not covered here
  assign lnk.pll_reset = pll_rst_q;
  assign lnk.block_powerdown = pd_q;
  assign lnk.tx_digital_reset = {NCH{tx_rst_q}};
  assign lnk.rx_digital_reset = {NCH{rx_rst_q}};
  assign lnk.rx_analog_reset = {NCH{ana_q}};
  assign lnk.hold_reference = {NCH{href_q & manual_lock_in}};
  assign lnk.force_data = {NCH{fdat_q & manual_lock_in}};
  assign tx_up_out = txu_q;
  assign rx_up_out = rxu_q;
endmodule
`default_nettype wire

// >>> trc_link_asserts.sv
// Concurrent checks on the link between transceiver and controller
`timescale 1ns/1ps
`default_nettype none
module trc_link_asserts #(
  parameter int unsigned NCH = 4,
  parameter int unsigned PLL_RST_CYC = 10
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic pll_reset,
  input wire logic block_powerdown,
  input wire logic [NCH-1:0] tx_digital_reset,
  input wire logic [NCH-1:0] rx_digital_reset,
  input wire logic [NCH-1:0] rx_analog_reset,
  input wire logic [NCH-1:0] hold_reference,
  input wire logic [NCH-1:0] force_data,
  input wire logic pll_locked,
  input wire logic cal_busy,
  input wire logic [NCH-1:0] data_locked
);
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  // Cycles since release and PLL reset hold, both saturating
  always_comb begin
    up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
    hold_d = !pll_reset ? 8'h00 : (hold_q == 8'hFF) ? hold_q : hold_q + 8'h01;
  end
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      up_q <= 2'h0;
      hold_q <= 8'h00;
    end else begin
      up_q <= up_d;
      hold_q <= hold_d;
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  property p_busy_start;
    (up_q != 2'h3) |-> (cal_busy == (up_q != 2'h0));
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("cal_busy wrong after reset");
  property p_busy_end;
    $rose(cal_busy) |-> cal_busy [*8] ##[1:40] !cal_busy;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("cal_busy did not fall in time");
  property p_pll_rst;
    pll_reset |=> !pll_locked;
  endproperty
  a_pll_rst: assert property (p_pll_rst)
    else $error("pll_locked high under PLL reset");
  property p_pll_lock;
    $fell(pll_reset) |-> !pll_locked ##[1:12] pll_locked;
  endproperty
  a_pll_lock: assert property (p_pll_lock)
    else $error("pll_locked late");
  property p_pd_off;
    block_powerdown |=> (data_locked == '0);
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("data_locked high in powerdown");
  property p_pd_pll;
    (block_powerdown && pll_locked && !pll_reset) |=> pll_locked;
  endproperty
  a_pd_pll: assert property (p_pd_pll)
    else $error("powerdown dropped PLL lock");
  property p_ana;
    (rx_analog_reset != '0) |=>
      ((data_locked & $past(rx_analog_reset)) == '0);
  endproperty
  a_ana: assert property (p_ana)
    else $error("data_locked high under analog reset");
  property p_ref;
    ((hold_reference & ~force_data) == {NCH{1'b1}}) |=> (data_locked == '0);
  endproperty
  a_ref: assert property (p_ref)
    else $error("data_locked high in reference lock");
  property p_ctrl_hold;
    $fell(pll_reset) |-> (hold_q >= PLL_RST_CYC);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("PLL reset released too early");
  property p_bond;
    (tx_digital_reset == '0) || (&tx_digital_reset);
  endproperty
  a_bond: assert property (p_bond)
    else $error("bonded TX resets split");
  property p_rxd_rel;
    $fell(rx_digital_reset[0]) |-> (&data_locked);
  endproperty
  a_rxd_rel: assert property (p_rxd_rel)
    else $error("RX digital released before lock");
  c_busy: cover property ($fell(cal_busy));
  c_lock: cover property ($rose(&data_locked));
  c_ltd: cover property ($rose(force_data[0]));
  c_pd: cover property (block_powerdown);
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the transceiver and reset controller pair
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned N = trc_pkg::NUM_CH;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic manual_lock_in = 1'b0;
  logic tx_only_in = 1'b0;
  logic powerdown_in = 1'b0;
  logic [N-1:0] dv = 4'hF;
  logic tx_up_out;
  logic rx_up_out;
  logic [N-1:0] tx_rdy, rx_rdy, buf_on, tx_rdy_b, rx_rdy_b, buf_on_b;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  trc_if #(.NCH(N)) lnk ();
  trc_if #(.NCH(N)) lnk_b ();
  trc_xcvr #(.NCH(N)) i_trc_xcvr (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .lnk(lnk), .tx_data_valid_in(dv),
    .rx_data_valid_in(dv), .tx_ready_out(tx_rdy),
    .rx_ready_out(rx_rdy), .rx_buf_on_out(buf_on));
  trc_ctrl #(.NCH(N)) i_trc_ctrl (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .lnk(lnk), .manual_lock_in(manual_lock_in),
    .tx_only_in(tx_only_in), .powerdown_in(powerdown_in),
    .tx_up_out(tx_up_out), .rx_up_out(rx_up_out));
  // Second transceiver driven straight from the bench, off-sequence
  trc_xcvr #(.NCH(N)) i_trc_xcvr_b (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .lnk(lnk_b), .tx_data_valid_in(dv),
    .rx_data_valid_in(dv), .tx_ready_out(tx_rdy_b),
    .rx_ready_out(rx_rdy_b), .rx_buf_on_out(buf_on_b));
  trc_link_asserts #(.NCH(N), .PLL_RST_CYC(trc_pkg::PLL_RST_CYC))
    i_trc_link_asserts (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .pll_reset(lnk.pll_reset), .block_powerdown(lnk.block_powerdown),
    .tx_digital_reset(lnk.tx_digital_reset),
    .rx_digital_reset(lnk.rx_digital_reset),
    .rx_analog_reset(lnk.rx_analog_reset),
    .hold_reference(lnk.hold_reference), .force_data(lnk.force_data),
    .pll_locked(lnk.pll_locked), .cal_busy(lnk.cal_busy),
    .data_locked(lnk.data_locked));
  // Clock at 100 ns period
  initial forever #50 mclk_in = ~mclk_in;
  task automatic summarize();
    $display("Counts: %0d checks, %0d mismatches", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Whole run needs a few hundred cycles; the ceiling leaves wide room
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [N-1:0] e,
      input logic [N-1:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bounded wait for the controller's TX or RX up flag
  task automatic wait_up(input logic rx);
    for (int k = 0; k < 400; k++) begin
      if ((rx ? rx_up_out : tx_up_out) === 1'b1) begin
        break;
      end
      @(negedge mclk_in);
    end
    // Ready flags register one cycle after the up flag
    @(negedge mclk_in);
  endtask
  task automatic run_seq(input logic man, input logic txo);
    @(negedge mclk_in);
    reset_n_in = 1'b0;
    manual_lock_in = man;
    tx_only_in = txo;
    repeat (12) @(negedge mclk_in);
    chk("hold_reference", {N{man}}, lnk.hold_reference);
    reset_n_in = 1'b1;
    wait_up(1'b0);
    chk("tx_up", 4'hF, {N{tx_up_out}});
    chk("tx_ready", 4'hF, tx_rdy);
    chk("pll_locked", 4'hF, {N{lnk.pll_locked}});
    if (!txo) begin
      wait_up(1'b1);
      chk("rx_up", 4'hF, {N{rx_up_out}});
      chk("rx_ready", 4'hF, rx_rdy);
      chk("data_locked", 4'hF, lnk.data_locked);
      chk("force_data", {N{man}}, lnk.force_data);
      chk("hold_ref", 4'h0, lnk.hold_reference);
    end
    $display("Test sequence manual %0b tx_only %0b done", man, txo);
  endtask
  initial begin
    lnk_b.pll_reset = 1'b1;
    lnk_b.block_powerdown = 1'b0;
    lnk_b.tx_digital_reset = 4'hF;
    lnk_b.rx_digital_reset = 4'hF;
    lnk_b.rx_analog_reset = 4'hF;
    lnk_b.hold_reference = 4'h0;
    lnk_b.force_data = 4'h0;
    run_seq(1'b0, 1'b0);
    powerdown_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk("rx_buf_on", 4'h0, buf_on);
    chk("data_locked", 4'h0, lnk.data_locked);
    chk("tx_ready", 4'h0, tx_rdy);
    chk("pll_locked", 4'hF, {N{lnk.pll_locked}});
    powerdown_in = 1'b0;
    $display("Test powerdown done");
    run_seq(1'b1, 1'b0);
    run_seq(1'b0, 1'b1);
    // Per-channel lock select: auto, ref, data, both set
    repeat (20) @(negedge mclk_in);
    lnk_b.pll_reset = 1'b0;
    lnk_b.tx_digital_reset = 4'h0;
    lnk_b.hold_reference = 4'hA;
    lnk_b.force_data = 4'hC;
    repeat (20) @(negedge mclk_in);
    chk("b pll_locked", 4'hF, {N{lnk_b.pll_locked}});
    chk("b tx_ready", 4'hF, tx_rdy_b);
    lnk_b.rx_analog_reset = 4'h0;
    repeat (20) @(negedge mclk_in);
    chk("b data_locked", 4'hD, lnk_b.data_locked);
    lnk_b.rx_digital_reset = 4'h0;
    lnk_b.rx_analog_reset = 4'h1;
    repeat (4) @(negedge mclk_in);
    chk("b data_locked", 4'hC, lnk_b.data_locked);
    chk("b rx_ready", 4'hC, rx_rdy_b);
    chk("b rx_buf_on", 4'hF, buf_on_b);
    lnk_b.tx_digital_reset = 4'h2;
    lnk_b.rx_digital_reset = 4'h8;
    repeat (4) @(negedge mclk_in);
    chk("b tx_ready", 4'hD, tx_rdy_b);
    chk("b rx_ready", 4'h4, rx_rdy_b);
    lnk_b.pll_reset = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk("b pll_locked", 4'h0, {N{lnk_b.pll_locked}});
    chk("b data_locked", 4'hC, lnk_b.data_locked);
    chk("b rx_buf_on", 4'hF, buf_on_b);
    $display("Test direct lock select done");
    summarize();
  end
endmodule
`default_nettype wire
